// [core/spc_pkg.sv]
// shared constants, field layouts and types of the serial port controller
package spc_pkg;

  // special-function-register addresses
  localparam logic [7:0] SPC_ADDR_TX_BUFFER  = 8'h9A;
  localparam logic [7:0] SPC_ADDR_RX_BUFFER  = 8'h9B;
  localparam logic [7:0] SPC_ADDR_CONFIG_ONE = 8'hE8;
  localparam logic [7:0] SPC_ADDR_CONFIG_TWO = 8'hE9;
  localparam logic [7:0] SPC_ADDR_IRQ_STATUS = 8'hEA;

  // reset values
  localparam logic [7:0] SPC_RST_TX_BUFFER  = 8'h00;
  localparam logic [7:0] SPC_RST_RX_BUFFER  = 8'h00;
  localparam logic [7:0] SPC_RST_CONFIG_ONE = 8'h10;
  localparam logic [7:0] SPC_RST_CONFIG_TWO = 8'h00;

  // writable bits of each configuration register, the rest read as zero
  localparam logic [7:0] SPC_MASK_CONFIG_ONE = 8'h3F;
  localparam logic [7:0] SPC_MASK_CONFIG_TWO = 8'hFC;

  // status register bit positions
  localparam int SPC_STAT_RX_FULL  = 0;
  localparam int SPC_STAT_TX_EMPTY = 1;
  localparam int SPC_STAT_BUSY     = 2;
  localparam int SPC_STAT_RX_OVF   = 3;
  localparam int SPC_STAT_IRQ      = 4;

  // serial framing
  localparam int         SPC_BYTE_BITS  = 8;
  localparam logic [3:0] SPC_LAST_EDGE  = 4'hF;
  localparam logic [2:0] SPC_LAST_BIT   = 3'h7;
  localparam logic [7:0] SPC_IDLE_FILL  = 8'hFF;

  // half serial clock period in core cycles for rate codes 00..11 (divide 8..64)
  localparam logic [5:0] SPC_HALF_DIV8  = 6'h04;
  localparam logic [5:0] SPC_HALF_DIV16 = 6'h08;
  localparam logic [5:0] SPC_HALF_DIV32 = 6'h10;
  localparam logic [5:0] SPC_HALF_DIV64 = 6'h20;

  // serial_config_one fields
  typedef struct packed {
    logic [1:0] reserved;
    logic       irq_source_mode;
    logic       auto_select;
    logic       select_in_en;
    logic       rx_overflow_write_en;
    logic [1:0] clock_rate_sel;
  } spc_cfg_one_t;

  // serial_config_two fields
  typedef struct packed {
    logic       continuous_transfer_en;
    logic       port_enable;
    logic       open_drain_en;
    logic       master_select;
    logic       clock_polarity;
    logic       clock_phase;
    logic [1:0] reserved;
  } spc_cfg_two_t;

  // master sequencer states
  typedef enum logic [1:0] {
    SPC_M_IDLE,
    SPC_M_SHIFT,
    SPC_M_GAP
  } spc_mstate_t;

endpackage : spc_pkg

// [core/spc_port.sv]
// serial peripheral port: register file, master sequencer, slave engine, byte buffers
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - each transfer shifts eight bits out and eight in at the same time
// - received byte is held while the next one shifts in
// - next transmit byte can be written while the current one shifts out
// - port runs as clock-driving master or as responding slave
// - port is idle unless the shared pins are given to it
// - writing tx_buffer queues the byte; the queued byte is what is sent
// - reading rx_buffer takes the held byte; new bytes fill the holder
// - irq_source_mode 0 flags a full receiver, 1 an empty transmitter
// - master with automatic select clear holds select low
// - master with automatic select, single byte: select low for the byte
// - master with automatic select, continuous: select low for the whole run
// - slave with select input enabled only answers while select is low
// - overflow write disabled: byte arriving on unread data is dropped
// - overflow write enabled: arriving byte overwrites unread data
// - master clock is core clock over 8, 16, 32 or 64
// - master_select 0 is slave, 1 is master
// - clock_polarity sets the idle level and first edge direction
// - clock_phase picks which edge changes data and which samples
// - continuous mode keeps going while transmit data remains
module spc_port (
  input  wire logic             ref_clk_i,
  input  wire logic             arst_n_i,
  input  wire logic [7:0]       sfr_addr_i,
  input  wire logic             sfr_wr_i,
  input  wire logic             sfr_rd_i,
  input  wire logic [7:0]       sfr_wdata_i,
  output var  logic [7:0]       sfr_rdata_o,
  input  wire logic             peripheral_select_i,
  output var  logic             spi_irq_o,
  input  wire logic             sclk_i,
  output var  logic             sclk_o,
  output var  logic             sclk_oe_o,
  input  wire logic             mosi_i,
  output var  logic             mosi_o,
  output var  logic             mosi_oe_o,
  input  wire logic             miso_i,
  output var  logic             miso_o,
  output var  logic             miso_oe_o,
  input  wire logic             ss_n_i,
  output var  logic             ss_n_o,
  output var  logic             ss_n_oe_o
);
  import spc_pkg::*;

  spc_cfg_one_t cfg_one_r;
  spc_cfg_two_t cfg_two_r;
  logic [7:0]   tx_hold_r;
  logic         tx_valid_r;
  logic [7:0]   rx_data_r;
  logic         rx_full_r;
  logic         rx_ovf_r;
  logic [7:0]   tx_sh_r;
  logic [7:0]   rx_sh_r;
  logic [2:0]   bit_cnt_r;
  logic         byte_done_r;
  logic         out_bit_r;
  logic [5:0]   div_cnt_r;
  logic [3:0]   edge_cnt_r;
  spc_mstate_t  mstate_r;
  logic         sclk_q_r;
  logic         slv_sel_q_r;
  logic         ss_drive_r;

  logic         wr_tx;
  logic         rd_rx;
  logic         wr_cfg_one;
  logic         wr_cfg_two;
  logic         wr_stat;
  logic         spi_on;
  logic         is_master;
  logic         is_slave;
  logic         slv_sel;
  logic         slv_start;
  logic         slv_edge;
  logic         slv_first;
  logic [5:0]   half_div;
  logic         tick;
  logic         m_start;
  logic         m_next;
  logic         m_edge;
  logic         m_first;
  logic         smp_ev;
  logic         chg_ev;
  logic         load_ev;
  logic         preload;
  logic         din;
  logic [7:0]   load_byte;
  logic [7:0]   status;

  ////////////////////////////////////////////////////////////////////////////
  // register decode
  assign wr_tx      = sfr_wr_i && (sfr_addr_i == SPC_ADDR_TX_BUFFER);
  assign rd_rx      = sfr_rd_i && (sfr_addr_i == SPC_ADDR_RX_BUFFER);
  assign wr_cfg_one = sfr_wr_i && (sfr_addr_i == SPC_ADDR_CONFIG_ONE);
  assign wr_cfg_two = sfr_wr_i && (sfr_addr_i == SPC_ADDR_CONFIG_TWO);
  assign wr_stat    = sfr_wr_i && (sfr_addr_i == SPC_ADDR_IRQ_STATUS);

  // the pins belong to the port only when the shared-pin select gives them to it
  assign spi_on    = cfg_two_r.port_enable && !peripheral_select_i;
  assign is_master = spi_on && cfg_two_r.master_select;
  assign is_slave  = spi_on && !cfg_two_r.master_select;

  // slave is addressed by a low select pin only when the select input is enabled
  assign slv_sel   = is_slave && (!cfg_one_r.select_in_en || !ss_n_i);
  assign slv_start = slv_sel && !slv_sel_q_r;
  assign slv_edge  = slv_sel && slv_sel_q_r && (sclk_i != sclk_q_r);
  // leaving the idle level is the first edge of a bit
  assign slv_first = (sclk_q_r == cfg_two_r.clock_polarity);

  ////////////////////////////////////////////////////////////////////////////
  // master clock divider, one enable pulse each half serial period
  always_comb
  begin
    unique case (cfg_one_r.clock_rate_sel)
      2'b00: half_div = SPC_HALF_DIV8;
      2'b01: half_div = SPC_HALF_DIV16;
      2'b10: half_div = SPC_HALF_DIV32;
      2'b11: half_div = SPC_HALF_DIV64;
    endcase
  end

  assign tick = (div_cnt_r == half_div - 6'h01);

  // divider restarts while idle so the first edge trails select by a half period
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      div_cnt_r <= 6'h00;
    else if (!is_master || (mstate_r == SPC_M_IDLE && !tx_valid_r) || tick)
      div_cnt_r <= 6'h00;
    else
      div_cnt_r <= div_cnt_r + 6'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // master sequencer
  assign m_start = is_master && (mstate_r == SPC_M_IDLE) && tx_valid_r && tick;
  assign m_next  = is_master && (mstate_r == SPC_M_GAP) && tick
                   && cfg_two_r.continuous_transfer_en && tx_valid_r;
  assign m_edge  = is_master && (mstate_r == SPC_M_SHIFT) && tick;
  assign m_first = !edge_cnt_r[0];

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      mstate_r   <= SPC_M_IDLE;
      edge_cnt_r <= 4'h0;
    end
    else if (!is_master)
    begin
      mstate_r   <= SPC_M_IDLE;
      edge_cnt_r <= 4'h0;
    end
    else
    begin
      unique case (mstate_r)
        SPC_M_IDLE:
        begin
          if (m_start)
            mstate_r <= SPC_M_SHIFT;
          edge_cnt_r <= 4'h0;
        end
        SPC_M_SHIFT:
        begin
          // sixteen clock edges carry one byte
          if (tick)
          begin
            edge_cnt_r <= edge_cnt_r + 4'h1;
            if (edge_cnt_r == SPC_LAST_EDGE)
              mstate_r <= SPC_M_GAP;
          end
        end
        SPC_M_GAP:
        begin
          edge_cnt_r <= 4'h0;
          if (m_next)
            mstate_r <= SPC_M_SHIFT;
          else if (tick)
            mstate_r <= SPC_M_IDLE;
        end
      endcase
    end
  end

  // serial clock out, parked at the idle level between bytes
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      sclk_o <= 1'b0;
    else if (m_edge)
      sclk_o <= !sclk_o;
    else if (mstate_r != SPC_M_SHIFT)
      sclk_o <= cfg_two_r.clock_polarity;
  end

  // select drive: manual low, or low around one byte or a whole continuous run
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      ss_drive_r <= 1'b0;
    else if (!is_master)
      ss_drive_r <= 1'b0;
    else if (!cfg_one_r.auto_select)
      ss_drive_r <= 1'b1;
    else if (m_start)
      ss_drive_r <= 1'b1;
    else if (mstate_r == SPC_M_GAP && tick && !m_next)
      ss_drive_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared shift engine, events from the master sequencer or the slave pins
  always_comb
  begin
    if (is_master)
    begin
      smp_ev  = m_edge && (m_first != cfg_two_r.clock_phase);
      chg_ev  = m_edge && (m_first == cfg_two_r.clock_phase);
      load_ev = m_start || m_next;
      preload = !cfg_two_r.clock_phase;
      din     = miso_i;
    end
    else
    begin
      smp_ev  = slv_edge && (slv_first != cfg_two_r.clock_phase);
      chg_ev  = slv_edge && (slv_first == cfg_two_r.clock_phase);
      load_ev = slv_start || byte_done_r;
      // the phase-0 slave must show its first bit before any edge
      preload = slv_start && !cfg_two_r.clock_phase;
      din     = mosi_i;
    end
  end

  // an empty holder sends ones rather than stale data
  assign load_byte = tx_valid_r ? tx_hold_r : SPC_IDLE_FILL;

  // transmit shifter and output bit, msb leaves first
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tx_sh_r   <= 8'h00;
      out_bit_r <= 1'b0;
    end
    else if (load_ev && preload)
    begin
      out_bit_r <= load_byte[SPC_BYTE_BITS-1];
      tx_sh_r   <= {load_byte[SPC_BYTE_BITS-2:0], 1'b0};
    end
    else if (load_ev)
      tx_sh_r <= load_byte;
    else if (chg_ev)
    begin
      out_bit_r <= tx_sh_r[SPC_BYTE_BITS-1];
      tx_sh_r   <= {tx_sh_r[SPC_BYTE_BITS-2:0], 1'b0};
    end
  end

  // receive shifter, bits enter at the bottom so the first one ends as msb
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rx_sh_r     <= 8'h00;
      bit_cnt_r   <= 3'h0;
      byte_done_r <= 1'b0;
    end
    else
    begin
      byte_done_r <= smp_ev && (bit_cnt_r == SPC_LAST_BIT);
      if (!is_master && !slv_sel)
        bit_cnt_r <= 3'h0;
      else if (smp_ev)
      begin
        rx_sh_r   <= {rx_sh_r[SPC_BYTE_BITS-2:0], din};
        bit_cnt_r <= bit_cnt_r + 3'h1;
      end
    end
  end

  // slave-side edge history
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sclk_q_r    <= 1'b0;
      slv_sel_q_r <= 1'b0;
    end
    else
    begin
      sclk_q_r    <= sclk_i;
      slv_sel_q_r <= slv_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit holder: a write in the cycle of a load keeps the new byte queued
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tx_hold_r  <= SPC_RST_TX_BUFFER;
      tx_valid_r <= 1'b0;
    end
    else if (wr_tx)
    begin
      tx_hold_r  <= sfr_wdata_i;
      tx_valid_r <= 1'b1;
    end
    else if (load_ev)
      tx_valid_r <= 1'b0;
  end

  // receive holder: arriving byte beats the read that clears the full flag
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rx_data_r <= SPC_RST_RX_BUFFER;
      rx_full_r <= 1'b0;
      rx_ovf_r  <= 1'b0;
    end
    else
    begin
      if (byte_done_r && (!rx_full_r || rd_rx || cfg_one_r.rx_overflow_write_en))
      begin
        rx_data_r <= rx_sh_r;
        rx_full_r <= 1'b1;
      end
      else if (rd_rx)
        rx_full_r <= 1'b0;
      // an unread byte hit by a new one is flagged whether dropped or replaced
      if (byte_done_r && rx_full_r && !rd_rx)
        rx_ovf_r <= 1'b1;
      else if (wr_stat && sfr_wdata_i[SPC_STAT_RX_OVF])
        rx_ovf_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cfg_one_r <= spc_cfg_one_t'(SPC_RST_CONFIG_ONE);
      cfg_two_r <= spc_cfg_two_t'(SPC_RST_CONFIG_TWO);
    end
    else
    begin
      if (wr_cfg_one)
        cfg_one_r <= spc_cfg_one_t'(sfr_wdata_i & SPC_MASK_CONFIG_ONE);
      if (wr_cfg_two)
        cfg_two_r <= spc_cfg_two_t'(sfr_wdata_i & SPC_MASK_CONFIG_TWO);
    end
  end

  // status view of the engine
  always_comb
  begin
    status                    = 8'h00;
    status[SPC_STAT_RX_FULL]  = rx_full_r;
    status[SPC_STAT_TX_EMPTY] = !tx_valid_r;
    status[SPC_STAT_BUSY]     = (mstate_r != SPC_M_IDLE) || slv_sel;
    status[SPC_STAT_RX_OVF]   = rx_ovf_r;
    status[SPC_STAT_IRQ]      = spi_irq_o;
  end

  // read data is registered, valid the cycle after the read strobe
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      sfr_rdata_o <= 8'h00;
    else if (sfr_rd_i)
    begin
      unique case (sfr_addr_i)
        SPC_ADDR_RX_BUFFER:  sfr_rdata_o <= rx_data_r;
        SPC_ADDR_CONFIG_ONE: sfr_rdata_o <= cfg_one_r;
        SPC_ADDR_CONFIG_TWO: sfr_rdata_o <= cfg_two_r;
        SPC_ADDR_IRQ_STATUS: sfr_rdata_o <= status;
        default:             sfr_rdata_o <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt level follows the chosen buffer condition
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      spi_irq_o <= 1'b0;
    else
      spi_irq_o <= spi_on && (cfg_one_r.irq_source_mode ? !tx_valid_r : rx_full_r);
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers registered, select data tied low; one data flop feeds whichever line we own
  assign mosi_o = out_bit_r;
  assign miso_o = out_bit_r;
  assign ss_n_o = 1'b0;

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sclk_oe_o <= 1'b0;
      mosi_oe_o <= 1'b0;
      miso_oe_o <= 1'b0;
      ss_n_oe_o <= 1'b0;
    end
    else
    begin
      sclk_oe_o <= is_master;
      mosi_oe_o <= is_master;
      miso_oe_o <= slv_sel;
      // select low is driven, otherwise released to the pull-up
      ss_n_oe_o <= is_master && (ss_drive_r || !cfg_one_r.auto_select);
    end
  end

endmodule : spc_port

`default_nettype wire

// [verif/spc_port_checker.sv]
// concurrent checks on the serial port controller pins and register bus
`timescale 1ns/1ps
`default_nettype none
module spc_port_checker
  import spc_pkg::*;
(
  input wire logic       ref_clk_i,
  input wire logic       arst_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_wr_i,
  input wire logic       sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       peripheral_select_i,
  input wire logic       sclk_o,
  input wire logic       sclk_oe_o,
  input wire logic       mosi_oe_o,
  input wire logic       miso_oe_o,
  input wire logic       ss_n_oe_o
);
  spc_cfg_one_t c1_r;
  spc_cfg_two_t c2_r;
  logic [5:0]   cnt_r;
  logic [5:0]   half;
  logic [7:0]   edg_r;
  logic         seen_r;
  logic         en;
  logic         ms;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  ////////////////////////////////////////////////////////////////////////////
  // shadow copies of both configuration registers, taken from bus writes
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      c1_r <= SPC_RST_CONFIG_ONE;
      c2_r <= SPC_RST_CONFIG_TWO;
    end
    else if (sfr_wr_i && sfr_addr_i == SPC_ADDR_CONFIG_ONE)
      c1_r <= sfr_wdata_i & SPC_MASK_CONFIG_ONE;
    else if (sfr_wr_i && sfr_addr_i == SPC_ADDR_CONFIG_TWO)
      c2_r <= sfr_wdata_i & SPC_MASK_CONFIG_TWO;
  end

  // cycles since the last clock change, and clock edges inside one select
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt_r  <= 6'h00;
      edg_r  <= 8'h00;
      seen_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= $changed(sclk_o) ? 6'h00 : cnt_r + 6'h01;
      seen_r <= ss_n_oe_o && (seen_r || $changed(sclk_o));
      edg_r  <= !ss_n_oe_o ? 8'h00 : edg_r + {7'h00, $changed(sclk_o)};
    end
  end

  // half period per rate code; modulo test works because all are powers of two
  always_comb
  begin
    case (c1_r.clock_rate_sel)
      2'b00:   half = SPC_HALF_DIV8;
      2'b01:   half = SPC_HALF_DIV16;
      2'b10:   half = SPC_HALF_DIV32;
      default: half = SPC_HALF_DIV64;
    endcase
  end
  assign en = c2_r.port_enable && !peripheral_select_i;
  assign ms = en && c2_r.master_select;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_sel_end;
    $fell(ss_n_oe_o) && ms && c1_r.auto_select && edg_r != 8'h00;
  endsequence
  property p_sclk_rate;
    $changed(sclk_o) && seen_r && ms
      |-> (((cnt_r + 6'h01) & (half - 6'h01)) == 6'h00) && (cnt_r >= half - 6'h01);
  endproperty
  a_sclk_rate: assert property (p_sclk_rate) else $error("serial clock edge off rate");
  property p_byte_edges;
    s_sel_end |-> edg_r[3:0] == 4'h0 && (c2_r.continuous_transfer_en || edg_r == 8'h10);
  endproperty
  a_byte_edges: assert property (p_byte_edges) else $error("select edge count wrong");
  property p_manual_ss;
    (ms && !c1_r.auto_select) [*2] |-> ss_n_oe_o;
  endproperty
  a_manual_ss: assert property (p_manual_ss) else $error("manual select not low");
  property p_shared;
    peripheral_select_i [*2] |-> !(sclk_oe_o || mosi_oe_o || miso_oe_o || ss_n_oe_o);
  endproperty
  a_shared: assert property (p_shared) else $error("pins driven while given away");
  property p_master_oe;
    ms [*2] |-> sclk_oe_o && mosi_oe_o;
  endproperty
  a_master_oe: assert property (p_master_oe) else $error("master not driving");
  property p_slave_oe;
    (en && !c2_r.master_select) [*2] |-> !sclk_oe_o && !mosi_oe_o;
  endproperty
  a_slave_oe: assert property (p_slave_oe) else $error("slave drives clock");
  property p_idle_level;
    (ms && c1_r.auto_select && !ss_n_oe_o && $stable(c2_r)) [*3]
      |-> sclk_o == c2_r.clock_polarity;
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("clock idle level wrong");
  property p_rdata_hold;
    !sfr_rd_i |=> $stable(sfr_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_cfg_read;
    sfr_rd_i && !sfr_wr_i && sfr_addr_i == SPC_ADDR_CONFIG_TWO |=> sfr_rdata_o == $past(c2_r);
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config readback wrong");
endmodule : spc_port_checker

bind spc_port spc_port_checker u_chk (
  .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .sfr_addr_i(sfr_addr_i),
  .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
  .sfr_rdata_o(sfr_rdata_o), .peripheral_select_i(peripheral_select_i),
  .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o), .mosi_oe_o(mosi_oe_o),
  .miso_oe_o(miso_oe_o), .ss_n_oe_o(ss_n_oe_o)
);
`default_nettype wire

// [verif/spc_slave_model.sv]
// behavioural serial slave answering the controller in master mode
`timescale 1ns/1ps
`default_nettype none
module spc_slave_model (
  input  wire logic       sclk_i,
  input  wire logic       ss_n_i,
  input  wire logic       mosi_i,
  input  wire logic       cpol_i,
  input  wire logic       cpha_i,
  output var  logic       miso_o,
  output var  logic [7:0] rx_o,
  output var  logic [7:0] cnt_o
);
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  logic [3:0] nbit;
  logic       skip;

  initial
  begin
    miso_o = 1'b0;
    rx_o   = 8'h00;
    cnt_o  = 8'h00;
    rx_sh  = 8'h00;
  end
  // byte k answered is 5A xor k; first bit shown early when sampling leads
  always @(negedge ss_n_i)
  begin
    tx_sh = 8'h5A ^ cnt_o;
    nbit  = 4'h0;
    skip  = 1'b0;
    if (!cpha_i)
      miso_o = tx_sh[7];
  end
  // a released line shows the inverse of its last level, never a stale bit
  always @(posedge ss_n_i)
    miso_o = ~miso_o;
  // leading edge samples when phase is 0, trailing edge when 1
  always @(sclk_i)
  begin
    if (!ss_n_i)
    begin
      if ((sclk_i != cpol_i) ^ cpha_i)
      begin
        rx_sh = {rx_sh[6:0], mosi_i};
        nbit  = nbit + 4'h1;
        if (nbit == 4'h8)
        begin
          rx_o  = rx_sh;
          cnt_o = cnt_o + 8'h01;
          nbit  = 4'h0;
          tx_sh = 8'h5A ^ cnt_o;
          skip  = !cpha_i;
          if (!cpha_i)
            miso_o = tx_sh[7];
        end
      end
      else if (skip)
        skip = 1'b0;
      else if (cpha_i)
      begin
        miso_o = tx_sh[7];
        tx_sh  = tx_sh << 1;
      end
      else
      begin
        tx_sh  = tx_sh << 1;
        miso_o = tx_sh[7];
      end
    end
  end
endmodule : spc_slave_model
`default_nettype wire

// [verif/tb.sv]
// self-checking bench for the serial port controller in master and slave modes
`timescale 1ns/1ps
`default_nettype none
module tb;
  import spc_pkg::*;
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } spc_row_t;
  logic       ref_clk_i;
  logic       arst_n_i;
  logic       wr;
  logic       rd;
  logic       psel;
  logic       cpol;
  logic       cpha;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] rv;
  logic [7:0] rx_m;
  logic [7:0] bcnt;
  logic       sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, miso_m, ss_o, ss_oe, irq;
  int         n_fail;
  int         cmp_count;
  int         cyc;
  spc_row_t   rows [8];
  // pin levels: released select and mosi lines are pulled high
  wire sclk_p = sclk_oe ? sclk_o : cpol;
  wire mosi_p = mosi_oe ? mosi_o : 1'b1;
  wire miso_p = miso_oe ? miso_o : miso_m;
  wire ss_p   = ss_oe ? ss_o : 1'b1;

  spc_port dut (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
    .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .peripheral_select_i(psel),
    .spi_irq_o(irq), .sclk_i(sclk_p), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe),
    .mosi_i(mosi_p), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe), .miso_i(miso_p),
    .miso_o(miso_o), .miso_oe_o(miso_oe), .ss_n_i(ss_p), .ss_n_o(ss_o), .ss_n_oe_o(ss_oe));
  spc_slave_model u_slave (
    .sclk_i(sclk_p), .ss_n_i(ss_p), .mosi_i(mosi_p), .cpol_i(cpol), .cpha_i(cpha),
    .miso_o(miso_m), .rx_o(rx_m), .cnt_o(bcnt));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one-cycle strobes; read data is taken after the edge that accepted the read
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    #1;
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    @(posedge ref_clk_i);
    #1;
    wr = 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    @(posedge ref_clk_i);
    #1;
    addr = a;
    rd   = 1'b1;
    @(posedge ref_clk_i);
    #1;
    rd = 1'b0;
    rv = rdata;
  endtask : rd_reg
  task automatic wait_bytes(input logic [7:0] n);
    repeat (3000)
    begin
      if (bcnt == n)
        break;
      @(posedge ref_clk_i);
    end
    chk(bcnt, n);
    repeat (400)
    begin
      if (!ss_oe)
        break;
      @(posedge ref_clk_i);
    end
    repeat (4) @(posedge ref_clk_i);
  endtask : wait_bytes
  task automatic wait_tx_empty;
    repeat (40)
    begin
      rd_reg(SPC_ADDR_IRQ_STATUS);
      if (rv[SPC_STAT_TX_EMPTY])
        break;
    end
  endtask : wait_tx_empty

  ////////////////////////////////////////////////////////////////////////////
  // free-running core clock and a hang guard
  initial
  begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end

  // main sequence: register table rows, then transfers and the awkward cases
  initial
  begin
    {arst_n_i, wr, rd, psel, cpol, cpha, addr, wdata} = '0;
    rows = '{'{8'hE8, 1'b0, 8'h00, 8'h10}, '{8'hE9, 1'b0, 8'h00, 8'h00},
             '{8'h9B, 1'b0, 8'h00, 8'h00}, '{8'h9A, 1'b0, 8'h00, 8'h00},
             '{8'hE8, 1'b1, 8'hFF, 8'h3F}, '{8'hE9, 1'b1, 8'h03, 8'h00},
             '{8'h80, 1'b1, 8'h55, 8'h00}, '{8'h9B, 1'b1, 8'h77, 8'h00}};
    repeat (8) @(posedge ref_clk_i);
    #1;
    arst_n_i = 1'b1;
    foreach (rows[i])
    begin
      if (rows[i].wr)
        wr_reg(rows[i].addr, rows[i].wdata);
      rd_reg(rows[i].addr);
      chk(rv, rows[i].exp);
    end
    // each clock mode paired with the rate code of the same number, one byte each
    for (int m = 0; m < 4; m++)
    begin
      cpol = m[1];
      cpha = m[0];
      wr_reg(SPC_ADDR_CONFIG_ONE, {6'h04, m[1:0]});
      wr_reg(SPC_ADDR_CONFIG_TWO, {4'h5, m[1:0], 2'b00});
      wr_reg(SPC_ADDR_TX_BUFFER, 8'h96 + m[7:0]);
      wait_bytes(m[7:0] + 8'h01);
      chk(rx_m, 8'h96 + m[7:0]);
      rd_reg(SPC_ADDR_RX_BUFFER);
      chk(rv, 8'h5A ^ m[7:0]);
    end
    // continuous run with the second byte loaded mid-shift; byte arriving on unread data dropped
    {cpol, cpha} = 2'b00;
    wr_reg(SPC_ADDR_CONFIG_ONE, 8'h10);
    wr_reg(SPC_ADDR_CONFIG_TWO, 8'hD0);
    wr_reg(SPC_ADDR_TX_BUFFER, 8'h11);
    wait_tx_empty();
    wr_reg(SPC_ADDR_TX_BUFFER, 8'h22);
    wait_bytes(8'h06);
    chk(rx_m, 8'h22);
    rd_reg(SPC_ADDR_RX_BUFFER);
    chk(rv, 8'h5E);
    rd_reg(SPC_ADDR_IRQ_STATUS);
    chk(rv & 8'h08, 8'h08);
    wr_reg(SPC_ADDR_IRQ_STATUS, 8'h08);
    // same again with overwrite allowed
    wr_reg(SPC_ADDR_CONFIG_ONE, 8'h14);
    wr_reg(SPC_ADDR_TX_BUFFER, 8'h33);
    wait_tx_empty();
    wr_reg(SPC_ADDR_TX_BUFFER, 8'h44);
    wait_bytes(8'h08);
    rd_reg(SPC_ADDR_RX_BUFFER);
    chk(rv, 8'h5D);
    // interrupt source selection
    wr_reg(SPC_ADDR_CONFIG_ONE, 8'h30);
    repeat (2) @(posedge ref_clk_i);
    chk({7'h00, irq}, 8'h01);
    wr_reg(SPC_ADDR_CONFIG_ONE, 8'h10);
    wr_reg(SPC_ADDR_CONFIG_TWO, 8'h50);
    chk({7'h00, irq}, 8'h00);
    wr_reg(SPC_ADDR_TX_BUFFER, 8'h5C);
    wait_bytes(8'h09);
    chk({7'h00, irq}, 8'h01);
    rd_reg(SPC_ADDR_RX_BUFFER);
    chk(rv, 8'h52);
    repeat (2) @(posedge ref_clk_i);
    chk({7'h00, irq}, 8'h00);
    // manual select, shared pins, slave mode
    wr_reg(SPC_ADDR_CONFIG_ONE, 8'h00);
    repeat (2) @(posedge ref_clk_i);
    chk({7'h00, ss_p}, 8'h00);
    #1;
    psel = 1'b1;
    repeat (2) @(posedge ref_clk_i);
    chk({4'h0, sclk_oe, mosi_oe, miso_oe, ss_oe}, 8'h00);
    #1;
    psel = 1'b0;
    wr_reg(SPC_ADDR_CONFIG_TWO, 8'h40);
    repeat (16) #300 cpol = ~cpol;
    rd_reg(SPC_ADDR_RX_BUFFER);
    chk(rv, 8'hFF);
    repeat (2) @(posedge ref_clk_i);
    chk({4'h0, sclk_oe, mosi_oe, miso_oe, miso_o}, 8'h03);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
